/* File: design/msq_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "msq_consts.svh"
module msq_sequencer
	import msq_pkg::*;
#(
	parameter int DEPTH = `MSQ_MEM_DEPTH,
	parameter int DW = `MSQ_RDG_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire msq_cmd_t cmd,
	output logic cmd_ready,
	input wire logic ext_trig,
	input wire logic bus_trig,
	output logic meas_start,
	input wire logic meas_done,
	input wire logic [DW-1:0] meas_data,
	input wire logic sig_present,
	output msq_cfg_t cfg,
	output logic trig_wait,
	output logic mem_err,
	output logic out_valid,
	input wire logic out_ready,
	output logic [DW-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = `MSQ_CNT_W;

	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_ARM, ST_MEAS, ST_FETCH} msq_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// range / resolution decode

	function automatic logic [`MSQ_RNG_W-1:0] rng_hi(input msq_func_t f);
		case (f)
			FN_DCV, FN_RATIO: rng_hi = `MSQ_RNG_V_HI;
			FN_ACV: rng_hi = `MSQ_RNG_VAC_HI;
			FN_DCI: rng_hi = `MSQ_RNG_IDC_HI;
			FN_ACI: rng_hi = `MSQ_RNG_IAC_HI;
			FN_OHM2, FN_OHM4: rng_hi = `MSQ_RNG_R_HI;
			default: rng_hi = `MSQ_RNG_SINGLE;
		endcase
	endfunction

	function automatic logic [`MSQ_RNG_W-1:0] rng_lo(input msq_func_t f);
		case (f)
			FN_DCV, FN_RATIO, FN_ACV: rng_lo = `MSQ_RNG_V_LO;
			FN_DCI, FN_ACI: rng_lo = `MSQ_RNG_I_LO;
			FN_OHM2, FN_OHM4: rng_lo = `MSQ_RNG_R_LO;
			default: rng_lo = `MSQ_RNG_SINGLE;
		endcase
	endfunction

	function automatic msq_cfg_t decode(input msq_cmd_t c);
		msq_cfg_t r;
		r = '0;
		r.func = c.func;
		// range argument
		case (c.rng_sel)
			SEL_MIN: r.rng = rng_lo(c.func);
			SEL_MAX: r.rng = rng_hi(c.func);
			SEL_DEFAULT_CHOICE: r.autorange = 1'b1;
			default: r.rng = c.rng_val;
		endcase
		// resolution argument
		case (c.res_sel)
			SEL_MIN: begin
				r.meas_dig = DIG_6H;
				r.nplc = NPLC_100;
			end
			SEL_MAX: begin
				r.meas_dig = DIG_4H;
				r.nplc = NPLC_002;
			end
			SEL_DEFAULT_CHOICE: begin
				r.meas_dig = DIG_5H;
				r.nplc = NPLC_10;
			end
			default: begin
				r.meas_dig = c.res_val;
				r.nplc = (c.res_val == DIG_6H) ? NPLC_10 :
					(c.res_val == DIG_5H) ? NPLC_1 : NPLC_002;
			end
		endcase
		r.disp_dig = r.meas_dig;
		case (c.func)
			FN_RATIO: r.ref_autorange = 1'b1;
			FN_ACV, FN_ACI: r.meas_dig = DIG_6H;
			FN_FREQ, FN_PER: begin
				// one span covers every input, so autoranging means nothing here
				r.rng = `MSQ_RNG_SINGLE;
				r.autorange = 1'b0;
			end
			FN_CONT: begin
				r.rng = `MSQ_RNG_1K;
				r.autorange = 1'b0;
				r.meas_dig = DIG_5H;
				r.disp_dig = DIG_5H;
				r.nplc = NPLC_10;
			end
			FN_DIODE: begin
				r.rng = `MSQ_RNG_1V;
				r.autorange = 1'b0;
				r.meas_dig = DIG_5H;
				r.disp_dig = DIG_5H;
				r.nplc = NPLC_10;
				r.isrc_1ma = 1'b1;
			end
			default: ;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	msq_state_t state_q, state_d;
	msq_cfg_t cfg_q;
	msq_tsrc_t tsrc_q;
	logic [CW-1:0] samp_cnt_q, trig_cnt_q, samp_left_q, trig_left_q;
	logic to_mem_q, mem_err_q, start_q, ready_q, wait_q;
	logic [AW:0] wr_ptr_q, mem_cnt_q, rd_ptr_q;
	logic [DW-1:0] mem [DEPTH];
	logic v0_q, v1_q;
	logic [DW-1:0] d0_q, d1_q;

	////////////////////////////////////////////////////////////////////////////////
	// decode and selection

	wire idle = ready_q;
	wire take = cmd_valid & idle;
	wire msq_op_t op = take ? cmd.op : OP_NONE;
	wire [2*CW-1:0] total = samp_cnt_q * trig_cnt_q;
	wire overflow = total > (2*CW)'(DEPTH);
	wire trig_hit = (tsrc_q == TSRC_IMM) | ((tsrc_q == TSRC_EXT) & ext_trig) |
		((tsrc_q == TSRC_BUS) & bus_trig);
	wire no_sig = ~sig_present & ((cfg_q.func == FN_FREQ) | (cfg_q.func == FN_PER));
	wire [DW-1:0] rdg = no_sig ? '0 : meas_data;
	wire room = ~v1_q;
	wire got = (state_q == ST_MEAS) & meas_done;
	wire fetch_go = (state_q == ST_FETCH) & room;
	wire push = (got & ~to_mem_q) | fetch_go;
	wire [DW-1:0] push_d = fetch_go ? mem[rd_ptr_q[AW-1:0]] : rdg;
	wire pop = v0_q & out_ready;
	wire last_samp = (samp_left_q <= CW'(1));
	wire last_trig = (trig_left_q <= CW'(1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				case (op)
					OP_MEAS, OP_READ: state_d = ST_WAIT;
					OP_INIT: state_d = overflow ? ST_IDLE : ST_WAIT;
					OP_FETCH: state_d = (mem_cnt_q == '0) ? ST_IDLE : ST_FETCH;
					default: state_d = ST_IDLE;
				endcase
			end
			ST_WAIT: state_d = trig_hit ? ST_ARM : ST_WAIT;
			// buffer room is checked before starting, so a reading always has a slot
			ST_ARM: state_d = (to_mem_q | room) ? ST_MEAS : ST_ARM;
			ST_MEAS: begin
				if (meas_done) begin
					state_d = !last_samp ? ST_ARM : !last_trig ? ST_WAIT : ST_IDLE;
				end
			end
			ST_FETCH: begin
				if (room && rd_ptr_q + 1'b1 == mem_cnt_q) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer registers

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			start_q <= 1'b0;
			ready_q <= 1'b1;
			wait_q <= 1'b0;
		end else begin
			state_q <= state_d;
			start_q <= (state_q == ST_ARM) & (to_mem_q | room);
			// state flags held in flops so the ports carry no decode glitches
			ready_q <= (state_d == ST_IDLE);
			wait_q <= (state_d == ST_WAIT);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_q <= '0;
			tsrc_q <= TSRC_IMM;
			samp_cnt_q <= `MSQ_PRESET_CNT;
			trig_cnt_q <= `MSQ_PRESET_CNT;
		end else if (op == OP_MEAS || op == OP_CONF) begin
			cfg_q <= decode(cmd);
			tsrc_q <= TSRC_IMM;
			samp_cnt_q <= `MSQ_PRESET_CNT;
			trig_cnt_q <= `MSQ_PRESET_CNT;
		end else if (op == OP_TRIG_SET) begin
			tsrc_q <= cmd.tsrc;
			samp_cnt_q <= cmd.samp_cnt;
			trig_cnt_q <= cmd.trig_cnt;
		end
	end

	// the measure query starts before the new presets land, so counts reload from preset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			samp_left_q <= '0;
			trig_left_q <= '0;
			to_mem_q <= 1'b0;
		end else if (op == OP_MEAS) begin
			trig_left_q <= `MSQ_PRESET_CNT;
			to_mem_q <= 1'b0;
		end else if (op == OP_READ || op == OP_INIT) begin
			trig_left_q <= trig_cnt_q;
			to_mem_q <= (op == OP_INIT);
		end else if (state_q == ST_WAIT && trig_hit) begin
			samp_left_q <= (to_mem_q || op == OP_NONE) && tsrc_q != TSRC_IMM ? samp_cnt_q :
				(trig_left_q == `MSQ_PRESET_CNT && samp_cnt_q == '0) ? `MSQ_PRESET_CNT
				: samp_cnt_q;
		end else if (got) begin
			samp_left_q <= samp_left_q - 1'b1;
			if (last_samp) begin
				trig_left_q <= trig_left_q - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem_err_q <= 1'b0;
		end else if (op == OP_INIT) begin
			mem_err_q <= overflow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reading memory

	always_ff @(posedge ref_clk) begin
		if (got && to_mem_q) begin
			mem[wr_ptr_q[AW-1:0]] <= rdg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			mem_cnt_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (op == OP_INIT && !overflow) begin
				wr_ptr_q <= '0;
				mem_cnt_q <= '0;
			end else if (got && to_mem_q) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
				mem_cnt_q <= wr_ptr_q + 1'b1;
			end
			if (op == OP_FETCH) begin
				rd_ptr_q <= '0;
			end else if (fetch_go) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// two-entry output buffer; a stalled reader loses nothing

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			v0_q <= 1'b0;
			v1_q <= 1'b0;
			d0_q <= '0;
			d1_q <= '0;
		end else if (pop) begin
			v0_q <= v1_q | push;
			v1_q <= 1'b0;
			d0_q <= v1_q ? d1_q : push_d;
		end else if (push && !v0_q) begin
			v0_q <= 1'b1;
			d0_q <= push_d;
		end else if (push) begin
			v1_q <= 1'b1;
			d1_q <= push_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign cmd_ready = ready_q;
	assign trig_wait = wait_q;
	assign meas_start = start_q;
	assign cfg = cfg_q;
	assign mem_err = mem_err_q;
	assign out_valid = v0_q;
	assign out_data = d0_q;

endmodule
`default_nettype wire

/* File: shared/msq_consts.svh */
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
`define MSQ_MEM_DEPTH 512
`define MSQ_RDG_W 32
`define MSQ_CNT_W 10
`define MSQ_PRESET_CNT 10'h001
`define MSQ_RNG_W 3
// range codes: index into the range ladder of each function
`define MSQ_RNG_V_LO 3'h0
`define MSQ_RNG_V_HI 3'h4
`define MSQ_RNG_VAC_HI 3'h4
`define MSQ_RNG_I_LO 3'h0
`define MSQ_RNG_IDC_HI 3'h3
`define MSQ_RNG_IAC_HI 3'h1
`define MSQ_RNG_R_LO 3'h0
`define MSQ_RNG_R_HI 3'h6
`define MSQ_RNG_SINGLE 3'h0
`define MSQ_RNG_1K 3'h1
`define MSQ_RNG_1V 3'h1
// single frequency / period span
`define MSQ_FREQ_LO_HZ 3
`define MSQ_FREQ_HI_KHZ 300
`define MSQ_PER_HI_MS 330
`define MSQ_PER_LO_NS 3300
`endif

/* File: shared/msq_pkg.sv */
`include "msq_consts.svh"
package msq_pkg;
	typedef enum logic [3:0] {FN_DCV, FN_RATIO, FN_ACV, FN_DCI, FN_ACI, FN_OHM2, FN_OHM4,
		FN_FREQ, FN_PER, FN_CONT, FN_DIODE} msq_func_t;
	typedef enum logic [2:0] {OP_NONE, OP_MEAS, OP_CONF, OP_READ, OP_INIT, OP_FETCH,
		OP_TRIG_SET} msq_op_t;
	typedef enum logic [1:0] {SEL_VAL, SEL_MIN, SEL_MAX, SEL_DEFAULT_CHOICE} msq_sel_t;
	typedef enum logic [1:0] {DIG_4H, DIG_5H, DIG_6H} msq_dig_t;
	typedef enum logic [2:0] {NPLC_002, NPLC_02, NPLC_1, NPLC_10, NPLC_100} msq_nplc_t;
	typedef enum logic [1:0] {TSRC_IMM, TSRC_EXT, TSRC_BUS} msq_tsrc_t;
	typedef struct packed {
		msq_op_t op;
		msq_func_t func;
		msq_sel_t rng_sel;
		logic [`MSQ_RNG_W-1:0] rng_val;
		msq_sel_t res_sel;
		msq_dig_t res_val;
		msq_tsrc_t tsrc;
		logic [`MSQ_CNT_W-1:0] samp_cnt;
		logic [`MSQ_CNT_W-1:0] trig_cnt;
	} msq_cmd_t;
	typedef struct packed {
		msq_func_t func;
		logic [`MSQ_RNG_W-1:0] rng;
		logic autorange;
		logic ref_autorange;
		msq_dig_t meas_dig;
		msq_dig_t disp_dig;
		msq_nplc_t nplc;
		logic isrc_1ma;
	} msq_cfg_t;
endpackage

/* File: verification/msq_seq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "msq_consts.svh"
module msq_seq_sva
	import msq_pkg::*;
#(
	parameter int DEPTH = 512
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire msq_cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic meas_start,
	input wire msq_cfg_t cfg,
	input wire logic trig_wait,
	input wire logic mem_err
);
	wire acc = cmd_valid && cmd_ready;
	wire cf = acc && cmd.op == OP_CONF;
	// an initiate carries no counts of its own, so keep the ones last set
	logic [`MSQ_CNT_W-1:0] samp_q, trig_q;
	always_ff @(posedge ref_clk) begin
		if (rst || (acc && (cmd.op == OP_MEAS || cmd.op == OP_CONF))) begin
			samp_q <= `MSQ_PRESET_CNT;
			trig_q <= `MSQ_PRESET_CNT;
		end else if (acc && cmd.op == OP_TRIG_SET) begin
			samp_q <= cmd.samp_cnt;
			trig_q <= cmd.trig_cnt;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	//////////////////////////////
	sequence s_meas;
		acc && cmd.op == OP_MEAS;
	endsequence
	property p_meas_arm;
		s_meas |=> !cmd_ready && trig_wait;
	endproperty
	a_meas_arm: assert property (p_meas_arm) else $error("measure not armed");
	property p_conf_idle;
		cf |=> cmd_ready && !trig_wait && !meas_start;
	endproperty
	a_conf_idle: assert property (p_conf_idle) else $error("configure started");
	property p_busy_cfg;
		!cmd_ready && cmd_valid |=> $stable(cfg);
	endproperty
	a_busy_cfg: assert property (p_busy_cfg) else $error("busy command taken");
	property p_cont;
		cf && cmd.func == FN_CONT |=> cfg.rng == `MSQ_RNG_1K && cfg.meas_dig == DIG_5H;
	endproperty
	a_cont: assert property (p_cont) else $error("continuity setup");
	property p_diode;
		cf && cmd.func == FN_DIODE |=> cfg.rng == `MSQ_RNG_1V && cfg.isrc_1ma;
	endproperty
	a_diode: assert property (p_diode) else $error("diode setup");
	property p_ac;
		cf && (cmd.func == FN_ACV || cmd.func == FN_ACI) |=> cfg.meas_dig == DIG_6H;
	endproperty
	a_ac: assert property (p_ac) else $error("ac digits");
	property p_ratio;
		cf && cmd.func == FN_RATIO |=> cfg.ref_autorange;
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio reference");
	property p_mem_ovf;
		acc && cmd.op == OP_INIT && int'(samp_q) * int'(trig_q) > DEPTH
			|=> mem_err && cmd_ready;
	endproperty
	a_mem_ovf: assert property (p_mem_ovf) else $error("overflow missed");
	property p_init_fit;
		acc && cmd.op == OP_INIT && int'(samp_q) * int'(trig_q) <= DEPTH
			|=> !mem_err && !cmd_ready && trig_wait;
	endproperty
	a_init_fit: assert property (p_init_fit) else $error("initiate not armed");
endmodule
bind msq_sequencer msq_seq_sva #(.DEPTH(DEPTH)) chk_u (
	.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_ready(cmd_ready), .meas_start(meas_start), .cfg(cfg),
	.trig_wait(trig_wait), .mem_err(mem_err)
);
`default_nettype wire

/* File: verification/msq_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msq_engine_model #(
	parameter int LAT = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic meas_start,
	output logic meas_done,
	output logic [31:0] meas_data
);
	int cnt_q;
	logic [31:0] idx_q;
	// data flips when idle so a stale sample cannot pass as a reading
	always_ff @(posedge ref_clk) begin
		meas_done <= 1'b0;
		meas_data <= ~meas_data;
		if (rst) begin
			cnt_q <= 0;
			idx_q <= 32'ha000;
			meas_data <= 32'h5a5a5a5a;
		end else if (meas_start) begin
			cnt_q <= LAT;
		end else if (cnt_q == 1) begin
			cnt_q <= 0;
			meas_done <= 1'b1;
			meas_data <= idx_q;
			idx_q <= idx_q + 32'h1;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/measurement_command_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "msq_consts.svh"
module measurement_command_sequencer_tb
	import msq_pkg::*;
;
	typedef struct packed {
		msq_func_t f;
		msq_sel_t s;
		logic [2:0] r;
		logic a;
		msq_dig_t d;
	} msq_row_t;
	localparam msq_sel_t DF = SEL_DEFAULT_CHOICE;
	localparam msq_row_t ROWS [11] = '{
		'{FN_DCV, DF, 3'h0, 1'b1, DIG_5H},
		'{FN_RATIO, SEL_MAX, `MSQ_RNG_V_HI, 1'b0, DIG_5H},
		'{FN_ACV, SEL_MAX, `MSQ_RNG_VAC_HI, 1'b0, DIG_6H},
		'{FN_DCI, SEL_MAX, `MSQ_RNG_IDC_HI, 1'b0, DIG_5H},
		'{FN_ACI, SEL_MAX, `MSQ_RNG_IAC_HI, 1'b0, DIG_6H},
		'{FN_OHM2, SEL_MIN, `MSQ_RNG_R_LO, 1'b0, DIG_5H},
		'{FN_OHM4, SEL_MAX, `MSQ_RNG_R_HI, 1'b0, DIG_5H},
		'{FN_FREQ, SEL_MAX, `MSQ_RNG_SINGLE, 1'b0, DIG_5H},
		'{FN_PER, SEL_MIN, `MSQ_RNG_SINGLE, 1'b0, DIG_5H},
		'{FN_CONT, SEL_MAX, `MSQ_RNG_1K, 1'b0, DIG_5H},
		'{FN_DIODE, DF, `MSQ_RNG_1V, 1'b0, DIG_5H}
	};
	logic ref_clk = 1'b0;
	logic rst = 1'b1, cmd_valid = 1'b0, ext_trig = 1'b0, bus_trig = 1'b0;
	logic sig_present = 1'b1, out_ready = 1'b1;
	msq_cmd_t cmd = '0;
	logic cmd_ready, meas_start, meas_done, trig_wait, mem_err, out_valid;
	logic [31:0] meas_data, out_data, nrd = 32'ha000;
	logic [31:0] got [$];
	msq_cfg_t cfg;
	int err_count = 0, checks = 0;
	msq_sequencer #(.DEPTH(8)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .ext_trig(ext_trig), .bus_trig(bus_trig),
		.meas_start(meas_start), .meas_done(meas_done), .meas_data(meas_data),
		.sig_present(sig_present), .cfg(cfg), .trig_wait(trig_wait),
		.mem_err(mem_err), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data)
	);
	msq_engine_model #(.LAT(3)) eng_u (
		.ref_clk(ref_clk), .rst(rst), .meas_start(meas_start),
		.meas_done(meas_done), .meas_data(meas_data)
	);
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got.push_back(out_data);
	//////////////////////////////
	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok) begin
			err_count++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic issue(input msq_cmd_t c);
		cmd <= c;
		cmd_valid <= 1'b1;
		tick(1);
		cmd_valid <= 1'b0;
		tick(1);
	endtask
	task automatic send(input msq_op_t o, input msq_func_t f, input msq_sel_t s,
		input msq_tsrc_t t, input logic [9:0] sc, input logic [9:0] tc);
		issue(msq_cmd_t'{o, f, s, 3'h0, DF, DIG_5H, t, sc, tc});
	endtask
	task automatic idle;
		int n;
		tick(2);
		for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
			tick(1);
		tick(3);
	endtask
	task automatic want(input int k);
		chk(got.size() == k, "count");
		for (int i = 0; i < k && i < got.size(); i++)
			chk(got[i] === nrd + 32'(i), "data");
		nrd = nrd + 32'(k);
		got.delete();
	endtask
	task automatic bus_pulses(input int n);
		repeat (n) begin
			bus_trig <= 1'b1;
			tick(1);
			bus_trig <= 1'b0;
			tick(20);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		tick(20000);
		err_count++;
		complete_run;
	end
	initial begin
		tick(8);
		rst <= 1'b0;
		tick(1);
		chk(cmd_ready === 1'b1 && cfg === '0 && out_valid === 1'b0, "reset");
		foreach (ROWS[i]) begin
			send(OP_CONF, ROWS[i].f, ROWS[i].s, TSRC_IMM, 10'h1, 10'h1);
			chk(cfg.func === ROWS[i].f && cfg.autorange === ROWS[i].a, "func");
			chk(cfg.meas_dig === ROWS[i].d && (ROWS[i].a || cfg.rng === ROWS[i].r), "rng");
			chk(cfg.nplc === NPLC_10, "nplc");
			chk(trig_wait === 1'b0 && cmd_ready === 1'b1, "conf");
		end
		issue(msq_cmd_t'{OP_CONF, FN_DCV, SEL_VAL, 3'h2, SEL_MIN, DIG_5H,
			TSRC_IMM, 10'h1, 10'h1});
		chk(cfg.rng === 3'h2 && cfg.meas_dig === DIG_6H && cfg.nplc === NPLC_100, "res min");
		issue(msq_cmd_t'{OP_CONF, FN_OHM2, SEL_VAL, 3'h2, SEL_MAX, DIG_5H,
			TSRC_IMM, 10'h1, 10'h1});
		chk(cfg.meas_dig === DIG_4H && cfg.nplc === NPLC_002, "res max");
		issue(msq_cmd_t'{OP_CONF, FN_ACI, SEL_MIN, 3'h2, SEL_MAX, DIG_5H,
			TSRC_IMM, 10'h1, 10'h1});
		chk(cfg.meas_dig === DIG_6H && cfg.disp_dig === DIG_4H, "ac display");
		// counts and ext source would hang it if not forced back to presets
		send(OP_TRIG_SET, FN_DCV, DF, TSRC_EXT, 10'h5, 10'h5);
		send(OP_MEAS, FN_DCV, DF, TSRC_EXT, 10'h5, 10'h5);
		idle;
		want(1);
		chk(trig_wait === 1'b0, "not idle");
		send(OP_TRIG_SET, FN_DCV, DF, TSRC_EXT, 10'h1, 10'h1);
		send(OP_READ, FN_DCV, DF, TSRC_EXT, 10'h1, 10'h1);
		tick(10);
		chk(got.size() == 0 && trig_wait === 1'b1, "read wait");
		ext_trig <= 1'b1;
		tick(1);
		ext_trig <= 1'b0;
		idle;
		want(1);
		send(OP_TRIG_SET, FN_DCV, DF, TSRC_BUS, 10'h2, 10'h2);
		send(OP_INIT, FN_DCV, DF, TSRC_BUS, 10'h2, 10'h2);
		send(OP_CONF, FN_ACV, DF, TSRC_IMM, 10'h1, 10'h1);
		chk(cfg.func === FN_DCV, "busy taken");
		bus_pulses(2);
		idle;
		chk(got.size() == 0, "memory");
		out_ready <= 1'b0;
		send(OP_FETCH, FN_DCV, DF, TSRC_BUS, 10'h1, 10'h1);
		tick(20);
		chk(got.size() == 0 && out_valid === 1'b1, "stall");
		out_ready <= 1'b1;
		idle;
		want(4);
		send(OP_TRIG_SET, FN_DCV, DF, TSRC_BUS, 10'h3, 10'h3);
		send(OP_INIT, FN_DCV, DF, TSRC_BUS, 10'h3, 10'h3);
		chk(mem_err === 1'b1 && cmd_ready === 1'b1, "overflow");
		send(OP_TRIG_SET, FN_DCV, DF, TSRC_BUS, 10'h2, 10'h4);
		send(OP_INIT, FN_DCV, DF, TSRC_BUS, 10'h2, 10'h4);
		chk(mem_err === 1'b0, "exact fit");
		bus_pulses(4);
		idle;
		nrd = nrd + 32'h8;
		// a stalled reader must hold the read sequence, not drop readings
		send(OP_TRIG_SET, FN_DCV, DF, TSRC_IMM, 10'h4, 10'h1);
		out_ready <= 1'b0;
		send(OP_READ, FN_DCV, DF, TSRC_IMM, 10'h4, 10'h1);
		tick(40);
		chk(got.size() == 0 && out_valid === 1'b1 && cmd_ready === 1'b0, "read stall");
		out_ready <= 1'b1;
		idle;
		want(4);
		sig_present <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			send(OP_MEAS, k ? FN_PER : FN_FREQ, DF, TSRC_IMM, 10'h1, 10'h1);
			idle;
			chk(got.size() == 1 && got[0] === 32'h0, "no signal");
			got.delete();
		end
		complete_run;
	end
endmodule
`default_nettype wire
